// ==== verilog/pii_input_image.sv ====
// process input image: analog averaging, pin inputs, sensor words, retained area
`timescale 1ns/1ns
`include "pii_params.svh"

// Contract
// - 10-bit analog value in little-endian word
// - average ten conversions per analog channel
// - analog words range zero to 1023
// - separate word for analog channels zero, one
// - pin states in bits 0-3, upper zero
// - all pins inputs after reset
// - input plus output bit enables pull-up when control bit 4 is set
// - sensor temperature word indexed by pin
// - sensor humidity word indexed by pin
// - high-res temperature tenths, sign in msb
// - humidity times 256 or tenths
// - 64-byte retained area restored after restart
// - backup unchanged until new enabled backup
// - enabled retention backs up output on power loss
// - host selects input, output or sensor per pin
// - control bytes in, status bytes out
// - copy bit mirrors output area one cycle later
module pii_input_image
	import pii_pkg::*;
(
	// clock and reset
	input  wire logic             core_clk_in,
	input  wire logic             rst_b_in,
	// avalon-mm slave
	input  wire logic [7:0]       avs_address_in,
	input  wire logic             avs_read_in,
	input  wire logic             avs_write_in,
	input  wire logic [31:0]      avs_writedata_in,
	input  wire logic [3:0]       avs_byteenable_in,
	output logic      [31:0]      avs_readdata_out,
	output logic                  avs_waitrequest_out,
	// converter samples
	input  wire logic             adc_valid_in,
	input  wire logic [1:0][9:0]  adc_sample_in,
	// general-purpose pins and sensors
	input  wire logic [3:0]       pin_level_in,
	input  wire pii_sensor_type [3:0] sensor_in,
	// supply monitor
	input  wire logic             power_fail_in,
	// pin control
	output logic      [3:0]       pin_pull_up_out,
	output logic      [7:0]       pin_configuration_byte_out,
	output logic      [7:0]       pin_output_byte_out
);

	// ****************************************
	// state and retained memories
	// ****************************************
	pii_state_type   st_reg;
	pii_state_type   st_next;
	pii_bus_req_type req;
	logic [7:0]      retained_output_area [0:63];
	logic [7:0]      backup_store [0:63];
	logic [7:0]      retained_input_area [0:63];

	assign req = '{address: avs_address_in, read: avs_read_in,
		write: avs_write_in, writedata: avs_writedata_in,
		byteenable: avs_byteenable_in};

	// ****************************************
	// decode helpers
	// ****************************************
	function automatic logic in_window(input logic [7:0] addr,
		input logic [7:0] base, input logic [7:0] span);
		in_window = (addr >= base) && (addr < base + span);
	endfunction : in_window

	function automatic logic [1:0] pin_mode(input logic [7:0] cfg,
		input int idx);
		pin_mode = cfg[idx*2 +: 2];
	endfunction : pin_mode

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic [13:0] sum_w;
		logic [13:0] avg_w;
		logic [5:0]  widx;
		sum_w = 14'h0;
		avg_w = 14'h0;
		widx  = 6'h0;
		st_next = st_reg;
		st_next.waitreq = 1'b1;
		// pin states register, low nibble only
		st_next.pin_states = {4'h0, pin_level_in};
		// analog averaging over ten conversions
		if (adc_valid_in) begin
			for (int c = 0; c < 2; c++) begin
				sum_w = st_reg.adc_sum[c] + {4'h0, adc_sample_in[c]};
				if (st_reg.adc_count == `PII_AVG_COUNT - 4'd1) begin
					avg_w = sum_w / 14'd10;
					if (avg_w > {4'h0, `PII_ADC_MAX})
						avg_w = {4'h0, `PII_ADC_MAX};
					st_next.analog_word[c] = {6'h00, avg_w[9:0]};
					st_next.adc_sum[c] = 14'h0;
				end else begin
					st_next.adc_sum[c] = sum_w;
				end
			end
			if (st_reg.adc_count == `PII_AVG_COUNT - 4'd1)
				st_next.adc_count = 4'h0;
			else
				st_next.adc_count = st_reg.adc_count + 4'd1;
		end
		// sensor words, per pin in sensor mode
		for (int p = 0; p < 4; p++) begin
			if (pin_mode(st_reg.pin_config, p) == `PII_MODE_SENSOR
				&& sensor_in[p].valid) begin
				// low-res: integer in high byte; high-res: tenths, sign msb
				if (sensor_in[p].high_res) begin
					st_next.temp_word[p]  = sensor_in[p].temperature;
					st_next.humid_word[p] = sensor_in[p].humidity;
				end else begin
					st_next.temp_word[p] =
						{sensor_in[p].temperature[7:0], 8'h00};
					st_next.humid_word[p] =
						{sensor_in[p].humidity[7:0], 8'h00};
				end
			end
			// pull-up only for inputs with output bit set
			st_next.pull_up[p] = st_reg.uc_ctrl[`PII_CTRL_GPUE_BIT]
				&& pin_mode(st_reg.pin_config, p) == `PII_MODE_INPUT
				&& st_reg.pin_output[p];
		end
		// backup armed while retention enabled
		st_next.backup_pending = st_reg.uc_ctrl[`PII_CTRL_RE_BIT];
		// bus slave
		case (st_reg.bus_state)
			PII_BUS_IDLE: begin
				if (req.read || req.write) begin
					st_next.bus_state = PII_BUS_ANSWER;
					st_next.waitreq   = 1'b0;
					st_next.readdata  = `PII_UNMAPPED_DATA;
					widx = req.address[7:2] & 6'h0f;
					if (req.read) begin
						if (req.address == `PII_OFS_ANALOG0)
							st_next.readdata = {16'h0, st_reg.analog_word[0]};
						else if (req.address == `PII_OFS_ANALOG1)
							st_next.readdata = {16'h0, st_reg.analog_word[1]};
						else if (req.address == `PII_OFS_PIN_STATES)
							st_next.readdata = {24'h0, st_reg.pin_states};
						else if (req.address == `PII_OFS_PIN_CONFIG)
							st_next.readdata = {24'h0, st_reg.pin_config};
						else if (req.address == `PII_OFS_PIN_OUTPUT)
							st_next.readdata = {24'h0, st_reg.pin_output};
						else if (req.address == `PII_OFS_UC_CTRL)
							st_next.readdata = {24'h0, st_reg.uc_ctrl};
						else if (req.address == `PII_OFS_STATUS)
							st_next.readdata = {28'h0, st_reg.pull_up};
						else if (in_window(req.address, `PII_OFS_TEMP_BASE,
							8'h10))
							st_next.readdata = {16'h0,
								st_reg.temp_word[widx[1:0]]};
						else if (in_window(req.address, `PII_OFS_HUMID_BASE,
							8'h10))
							st_next.readdata = {16'h0,
								st_reg.humid_word[widx[1:0]]};
						else if (in_window(req.address, `PII_OFS_RET_IN_BASE,
							8'h40))
							st_next.readdata = {
								retained_input_area[{widx[3:0], 2'd3}],
								retained_input_area[{widx[3:0], 2'd2}],
								retained_input_area[{widx[3:0], 2'd1}],
								retained_input_area[{widx[3:0], 2'd0}]};
					end
				end
			end
			PII_BUS_ANSWER: begin
				st_next.bus_state = PII_BUS_IDLE;
				// writes land at the edge the master sees the answer
				if (req.write && req.byteenable[0]) begin
					if (req.address == `PII_OFS_PIN_CONFIG)
						st_next.pin_config = req.writedata[7:0];
					else if (req.address == `PII_OFS_PIN_OUTPUT)
						st_next.pin_output = req.writedata[7:0];
					else if (req.address == `PII_OFS_UC_CTRL)
						st_next.uc_ctrl = req.writedata[7:0];
				end
			end
			default: begin
				st_next.bus_state = PII_BUS_IDLE;
			end
		endcase
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_reg            <= '0;
			st_reg.bus_state  <= PII_BUS_IDLE;
			st_reg.waitreq    <= 1'b1;
			st_reg.pin_config <= `PII_RESET_CONFIG;
		end else begin
			st_reg <= st_next;
		end
	end

	// ****************************************
	// retained areas (no reset: survive restarts)
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < 64; gi++) begin : g_ret
			always_ff @(posedge core_clk_in) begin
				if (st_reg.bus_state == PII_BUS_ANSWER && req.write
					&& req.byteenable[gi % 4] && in_window(req.address,
					`PII_OFS_RET_OUT_BASE, 8'h40)
					&& req.address[5:2] == 4'(gi / 4))
					retained_output_area[gi] <= req.writedata[(gi%4)*8 +: 8];
				// only enabled power loss rewrites the backup
				if (power_fail_in && st_reg.backup_pending)
					backup_store[gi] <= retained_output_area[gi];
				if (st_reg.uc_ctrl[`PII_CTRL_RC_BIT])
					retained_input_area[gi] <= retained_output_area[gi];
				else
					retained_input_area[gi] <= backup_store[gi];
			end
		end
	endgenerate

	// ****************************************
	// outputs
	// ****************************************
	assign avs_readdata_out           = st_reg.readdata;
	assign avs_waitrequest_out        = st_reg.waitreq;
	assign pin_pull_up_out            = st_reg.pull_up;
	assign pin_configuration_byte_out = st_reg.pin_config;
	assign pin_output_byte_out        = st_reg.pin_output;

endmodule : pii_input_image

// ==== verilog/pii_params.svh ====
// offsets, field positions, reset values and counts for the process input image
`ifndef PII_PARAMS_SVH
`define PII_PARAMS_SVH

// ****************************************
// register byte offsets (word aligned)
// ****************************************
`define PII_OFS_ANALOG0      8'h00
`define PII_OFS_ANALOG1      8'h04
`define PII_OFS_PIN_STATES   8'h08
`define PII_OFS_PIN_CONFIG   8'h0c
`define PII_OFS_PIN_OUTPUT   8'h10
`define PII_OFS_UC_CTRL      8'h14
`define PII_OFS_STATUS       8'h18
`define PII_OFS_TEMP_BASE    8'h20
`define PII_OFS_HUMID_BASE   8'h30
`define PII_OFS_RET_IN_BASE  8'h40
`define PII_OFS_RET_OUT_BASE 8'h80

// ****************************************
// field layout and constants
// ****************************************
`define PII_AVG_COUNT        4'd10
`define PII_ADC_MAX          10'h3ff
`define PII_CTRL_RC_BIT      1
`define PII_CTRL_RE_BIT      2
`define PII_CTRL_GPUE_BIT    4
`define PII_MODE_INPUT       2'h0
`define PII_MODE_OUTPUT      2'h1
`define PII_MODE_SENSOR      2'h2
`define PII_RESET_BYTE       8'h00
`define PII_RESET_CONFIG     8'h00
`define PII_UNMAPPED_DATA    32'h00000000

`endif

// ==== verilog/pii_pkg.sv ====
// types of the process input image
package pii_pkg;

	typedef struct packed {
		logic [7:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} pii_bus_req_type;

	typedef struct packed {
		logic [15:0] temperature;
		logic [15:0] humidity;
		logic        valid;
		logic        high_res;
	} pii_sensor_type;

	typedef enum {
		PII_BUS_IDLE,
		PII_BUS_ANSWER
	} pii_bus_state_type;

	typedef struct packed {
		pii_bus_state_type bus_state;
		logic [31:0]       readdata;
		logic              waitreq;
		logic [1:0][13:0]  adc_sum;
		logic [3:0]        adc_count;
		logic [1:0][15:0]  analog_word;
		logic [7:0]        pin_states;
		logic [7:0]        pin_config;
		logic [7:0]        pin_output;
		logic [7:0]        uc_ctrl;
		logic [3:0][15:0]  temp_word;
		logic [3:0][15:0]  humid_word;
		logic [3:0]        pull_up;
		logic              backup_pending;
	} pii_state_type;

endpackage : pii_pkg

// ==== sim/pii_input_image_checker.sv ====
// assertions on the process input image ports
`timescale 1ns/1ns
`include "pii_params.svh"
module pii_input_image_checker
	import pii_pkg::*;
(
	input wire logic        core_clk_in,
	input wire logic        rst_b_in,
	input wire logic [7:0]  avs_address_in,
	input wire logic        avs_read_in,
	input wire logic        avs_write_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic        avs_waitrequest_out,
	input wire logic [3:0]  pin_pull_up_out,
	input wire logic [7:0]  pin_configuration_byte_out,
	input wire logic [7:0]  pin_output_byte_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	logic [7:0] ra_reg;
	logic       rd_reg;
	wire        req = avs_read_in | avs_write_in;
	wire        ans = !avs_waitrequest_out && rd_reg;
	always_ff @(posedge core_clk_in) begin
		ra_reg <= avs_address_in;
		rd_reg <= avs_read_in;
	end
	sequence seq_taken;
		req && avs_waitrequest_out;
	endsequence
	sequence seq_answer;
		!avs_waitrequest_out ##1 avs_waitrequest_out;
	endsequence
	a_answer_next: assert property (seq_taken |=> seq_answer)
		else $error("no one-cycle answer");
	a_no_spurious: assert property (!req && avs_waitrequest_out |=>
		avs_waitrequest_out) else $error("answer without request");
	a_pin_upper: assert property (ans && ra_reg == `PII_OFS_PIN_STATES |->
		avs_readdata_out[31:4] == 28'h0) else $error("pin bits");
	a_analog_range: assert property (ans && (ra_reg == `PII_OFS_ANALOG0 ||
		ra_reg == `PII_OFS_ANALOG1) |-> avs_readdata_out[31:10] == 22'h0)
		else $error("analog range");
	a_config_read: assert property (ans && ra_reg == `PII_OFS_PIN_CONFIG |->
		avs_readdata_out[7:0] == pin_configuration_byte_out)
		else $error("config readback");
	a_reset_state: assert property (disable iff (1'b0) !rst_b_in |->
		pin_configuration_byte_out == 8'h00 && pin_pull_up_out == 4'h0)
		else $error("reset state");
	a_pull_out: assert property ((pin_pull_up_out & ~(pin_output_byte_out[3:0]
		| $past(pin_output_byte_out[3:0]))) == 4'h0)
		else $error("pull-up without output bit");
	a_pull_input: assert property (pin_pull_up_out[0] |->
		pin_configuration_byte_out[1:0] == 2'h0 ||
		$past(pin_configuration_byte_out[1:0]) == 2'h0)
		else $error("pull-up on non-input");
endmodule : pii_input_image_checker
bind pii_input_image pii_input_image_checker chk_u (.core_clk_in, .rst_b_in,
	.avs_address_in, .avs_read_in, .avs_write_in, .avs_readdata_out,
	.avs_waitrequest_out, .pin_pull_up_out, .pin_configuration_byte_out,
	.pin_output_byte_out);

// ==== sim/pii_host_model.sv ====
// host model: avalon-mm master for process data cycles
`timescale 1ns/1ns
module pii_host_model (
	input  wire logic        clk_in,
	input  wire logic        waitrequest_in,
	input  wire logic [31:0] readdata_in,
	output logic      [7:0]  address_out,
	output logic             read_out,
	output logic             write_out,
	output logic      [31:0] writedata_out
);
	initial begin
		address_out = 8'h00;
		read_out = 1'b0;
		write_out = 1'b0;
		writedata_out = 32'h0;
	end
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_in);
		address_out <= a;
		writedata_out <= d;
		read_out <= !w;
		write_out <= w;
		do @(posedge clk_in); while (waitrequest_in !== 1'b0);
		q = readdata_in;
		read_out <= 1'b0;
		write_out <= 1'b0;
		writedata_out <= ~d;
	endtask : xfer
endmodule : pii_host_model

// ==== sim/pii_input_image_bench.sv ====
// bench for the process input image
`timescale 1ns/1ns
`include "pii_params.svh"
module pii_input_image_bench
	import pii_pkg::*;
;
	logic core_clk_in = 1'b0;
	logic rst_b_in;
	logic [7:0] b_addr;
	logic b_rd, b_wr, b_wt, adc_v = 1'b0, pf = 1'b0;
	logic [31:0] b_wd, b_rdat, q;
	logic [1:0][9:0] adc_s = '0;
	logic [3:0] lvl = 4'h0, pu;
	logic [7:0] cfg, pout;
	pii_sensor_type [3:0] sens = '0;
	int n_fail = 0;
	int compares = 0;
	always #5 core_clk_in = ~core_clk_in;
	pii_host_model host_u (.clk_in(core_clk_in), .waitrequest_in(b_wt),
		.readdata_in(b_rdat), .address_out(b_addr), .read_out(b_rd),
		.write_out(b_wr), .writedata_out(b_wd));
	pii_input_image dut_u (.core_clk_in, .rst_b_in, .avs_address_in(b_addr),
		.avs_read_in(b_rd), .avs_write_in(b_wr), .avs_writedata_in(b_wd),
		.avs_byteenable_in(4'hf), .avs_readdata_out(b_rdat),
		.avs_waitrequest_out(b_wt), .adc_valid_in(adc_v),
		.adc_sample_in(adc_s), .pin_level_in(lvl), .sensor_in(sens),
		.power_fail_in(pf), .pin_pull_up_out(pu),
		.pin_configuration_byte_out(cfg), .pin_output_byte_out(pout));
	task automatic chk(input string n, input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		host_u.xfer(1'b0, a, 32'h0, q);
		chk($sformatf("addr %h", a), q, e);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host_u.xfer(1'b1, a, d, q);
	endtask : wr
	task automatic pfail;
		@(posedge core_clk_in);
		pf <= 1'b1;
		repeat (3) @(posedge core_clk_in);
		pf <= 1'b0;
	endtask : pfail
	task automatic t_analog;
		for (int i = 0; i < 10; i++) begin
			@(posedge core_clk_in);
			adc_v <= 1'b1;
			adc_s <= {10'h3ff, 10'(i * 100)};
		end
		@(posedge core_clk_in);
		adc_v <= 1'b0;
		rd(`PII_OFS_ANALOG0, 32'h1c2);
		rd(`PII_OFS_ANALOG1, 32'h3ff);
	endtask : t_analog
	task automatic t_pins;
		@(posedge core_clk_in);
		lvl <= 4'ha;
		rd(`PII_OFS_PIN_STATES, 32'ha);
		wr(`PII_OFS_UC_CTRL, 32'h10);
		wr(`PII_OFS_PIN_OUTPUT, 32'h5);
		rd(`PII_OFS_PIN_OUTPUT, 32'h5);
		chk("pull-up", 32'(pu), 32'h5);
		wr(`PII_OFS_PIN_CONFIG, 32'h1);
		rd(`PII_OFS_PIN_CONFIG, 32'h1);
		chk("pull-up", 32'(pu), 32'h4);
	endtask : t_pins
	task automatic t_sensor;
		wr(`PII_OFS_PIN_CONFIG, 32'haa);
		@(posedge core_clk_in);
		sens[0] <= '{16'h0016, 16'h0029, 1'b1, 1'b0};
		sens[1] <= '{16'h80e0, 16'h01a1, 1'b1, 1'b1};
		rd(`PII_OFS_PIN_CONFIG, 32'haa);
		rd(`PII_OFS_TEMP_BASE, 32'h1600);
		rd(`PII_OFS_HUMID_BASE, 32'h2900);
		rd(`PII_OFS_TEMP_BASE + 8'h04, 32'h80e0);
		rd(`PII_OFS_HUMID_BASE + 8'h04, 32'h01a1);
	endtask : t_sensor
	task automatic t_retain;
		wr(`PII_OFS_RET_OUT_BASE, 32'h1234abcd);
		wr(`PII_OFS_UC_CTRL, 32'h02);
		rd(`PII_OFS_RET_IN_BASE, 32'h1234abcd);
		wr(`PII_OFS_UC_CTRL, 32'h04);
		pfail;
		wr(`PII_OFS_UC_CTRL, 32'h00);
		rd(`PII_OFS_RET_IN_BASE, 32'h1234abcd);
		wr(`PII_OFS_RET_OUT_BASE, 32'h5a5a0f0f);
		pfail;
		rd(`PII_OFS_RET_IN_BASE, 32'h1234abcd);
		rd(8'hfc, 32'h0);
		@(posedge core_clk_in);
		rst_b_in <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		rst_b_in <= 1'b1;
		rd(`PII_OFS_PIN_CONFIG, 32'h0);
		rd(`PII_OFS_TEMP_BASE, 32'h0);
		rd(`PII_OFS_RET_IN_BASE, 32'h1234abcd);
	endtask : t_retain
	task automatic stop_test;
		if (n_fail == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	initial begin
		rst_b_in <= 1'b0;
		repeat (3) @(posedge core_clk_in);
		rst_b_in <= 1'b1;
		rd(`PII_OFS_PIN_CONFIG, 32'h0);
		rd(`PII_OFS_ANALOG0, 32'h0);
		t_analog;
		t_pins;
		t_sensor;
		t_retain;
		stop_test;
	end
	initial begin
		repeat (3000) @(posedge core_clk_in);
		n_fail++;
		stop_test;
	end
endmodule : pii_input_image_bench
